/* File: rtl/cps_pkg.sv */
package cps_pkg;

	// ----------------------------------------
	// Pattern selection
	// ----------------------------------------
	typedef enum logic [3:0] {
		pattern_scrambled_idle,
		pattern_nyquist,
		pattern_half_nyquist,
		pattern_comma,
		pattern_low_freq_signal,
		pattern_k287_deemph,
		pattern_k287_flat,
		pattern_runs_deemph,
		pattern_runs_flat
	} cps_pattern_t;

	typedef enum logic [1:0] {
		CPS_IDLE,
		CPS_ACTIVE
	} cps_state_t;

	// ----------------------------------------
	// Symbol values (8-bit data, K flag separate)
	// ----------------------------------------
	localparam logic [7:0] SYM_D00 = 8'h00;
	localparam logic [7:0] SYM_D102 = 8'h4a;
	localparam logic [7:0] SYM_D243 = 8'h78;
	localparam logic [7:0] SYM_K285 = 8'hbc;
	localparam logic [7:0] SYM_K287 = 8'hfc;

	// ----------------------------------------
	// Scrambler, run lengths, FIFO depth and synchroniser stages
	// ----------------------------------------
	localparam logic [15:0] LFSR_SEED = 16'hffff;
	localparam logic [15:0] LFSR_TAPS = 16'h0039;
	localparam int RUN_MIN = 50;
	localparam int RUN_MAX = 250;
	localparam int RUN_DEFAULT = 100;
	localparam int FIFO_DEPTH = 32;
	localparam int SYNC_STAGES = 3;

endpackage : cps_pkg

/* File: rtl/cps_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

module cps_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Fill side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Drain side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign inReady = (count_q != (AW+1)'(DEPTH));
	assign outValid = (count_q != '0);
	assign outData = mem[rdPtr_q];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_ff @(posedge mclk)
	begin
		if (push)
		begin
			mem[wrPtr_q] <= inData;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
			begin
				wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
			end
			if (pop)
			begin
				rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : cps_fifo

`default_nettype wire

/* File: rtl/cps_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none

module cps_sequencer #(
	parameter int RUN_LEN = cps_pkg::RUN_DEFAULT,
	parameter int FIFO_DEPTH = cps_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Link training control
	input wire logic enterCompliance,
	output logic complianceActive,
	output logic complianceExit,
	// Receiver LFPS detection (asynchronous levels)
	input wire logic pingDetect,
	input wire logic resetDetect,
	// Transmit symbol stream
	output logic txValid,
	input wire logic txReady,
	output logic [7:0] txSymbol,
	output logic txIsK,
	output logic txDeemph,
	output logic txLfps,
	output logic txSkpAllowed,
	output logic [3:0] patternIndex
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [2:0] pingSync_q;
	logic [2:0] rstSync_q;
	logic pingLvl_q;
	logic rstLvl_q;
	logic pingEvt;
	logic rstEvt;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pingSync_q <= '0;
			rstSync_q <= '0;
			pingLvl_q <= 1'b0;
			rstLvl_q <= 1'b0;
		end
		else
		begin
			pingSync_q <= {pingSync_q[1:0], pingDetect};
			rstSync_q <= {rstSync_q[1:0], resetDetect};
			if (pingSync_q[1] == pingSync_q[2])
				pingLvl_q <= pingSync_q[2];
			if (rstSync_q[1] == rstSync_q[2])
				rstLvl_q <= rstSync_q[2];
		end
	end

	assign pingEvt = (pingSync_q[1] == pingSync_q[2]) && pingSync_q[2] && !pingLvl_q;
	assign rstEvt = (rstSync_q[1] == rstSync_q[2]) && rstSync_q[2] && !rstLvl_q;

	// ----------------------------------------
	// Substate and pattern selection
	// ----------------------------------------
	cps_pkg::cps_state_t state_q;
	cps_pkg::cps_pattern_t pattern_q;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= cps_pkg::CPS_IDLE;
			pattern_q <= cps_pkg::pattern_scrambled_idle;
			complianceExit <= 1'b0;
		end
		else
		begin
			complianceExit <= 1'b0;
			case (state_q)
				cps_pkg::CPS_IDLE:
					if (enterCompliance)
					begin
						state_q <= cps_pkg::CPS_ACTIVE;
						pattern_q <= cps_pkg::pattern_scrambled_idle;
					end
				cps_pkg::CPS_ACTIVE:
					if (rstEvt)
					begin
						state_q <= cps_pkg::CPS_IDLE;
						complianceExit <= 1'b1;
					end
					else if (pingEvt)
					begin
						if (pattern_q == cps_pkg::pattern_runs_flat)
							pattern_q <= cps_pkg::pattern_scrambled_idle;
						else
							pattern_q <= cps_pkg::cps_pattern_t'(pattern_q + 4'h1);
					end
				default: state_q <= cps_pkg::CPS_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Pattern generator into FIFO
	// ----------------------------------------
	logic active;
	logic [15:0] lfsr_q;
	logic [7:0] runCnt_q;
	logic runHigh_q;
	logic genValid;
	logic genReady;
	logic [7:0] genSym;
	logic genK;
	logic genDe;
	logic genLf;
	logic [11:0] fifoOut;
	logic fifoValid;
	logic fifoReady;

	assign active = (state_q == cps_pkg::CPS_ACTIVE);
	assign genValid = active;

	// scrambler advances only for the first pattern
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			lfsr_q <= cps_pkg::LFSR_SEED;
		else if (!active)
			lfsr_q <= cps_pkg::LFSR_SEED;
		else if (genReady && pattern_q == cps_pkg::pattern_scrambled_idle)
			lfsr_q <= {lfsr_q[14:0], ^(lfsr_q & cps_pkg::LFSR_TAPS)};
	end

	localparam int RUN_CEIL = (RUN_LEN + 7) / 8;
	localparam int RUN_BYTES = (RUN_CEIL * 8 > cps_pkg::RUN_MAX) ? RUN_CEIL - 1 : RUN_CEIL;
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			runCnt_q <= '0;
			runHigh_q <= 1'b1;
		end
		else if (!active)
		begin
			runCnt_q <= '0;
			runHigh_q <= 1'b1;
		end
		else if (genReady)
			if (runCnt_q == 8'(RUN_BYTES - 1))
			begin
				runCnt_q <= '0;
				runHigh_q <= !runHigh_q;
			end
			else
				runCnt_q <= runCnt_q + 8'h01;
	end

	always_comb
	begin
		genSym = cps_pkg::SYM_D00;
		genK = 1'b0;
		genDe = 1'b1;
		genLf = 1'b0;
		case (pattern_q)
			cps_pkg::pattern_scrambled_idle: genSym = cps_pkg::SYM_D00 ^ lfsr_q[15:8];
			cps_pkg::pattern_nyquist: genSym = cps_pkg::SYM_D102;
			cps_pkg::pattern_half_nyquist: genSym = cps_pkg::SYM_D243;
			cps_pkg::pattern_comma:
			begin
				genSym = cps_pkg::SYM_K285;
				genK = 1'b1;
			end
			cps_pkg::pattern_low_freq_signal: genLf = 1'b1;
			cps_pkg::pattern_k287_deemph:
			begin
				genSym = cps_pkg::SYM_K287;
				genK = 1'b1;
			end
			cps_pkg::pattern_k287_flat:
			begin
				genSym = cps_pkg::SYM_K287;
				genK = 1'b1;
				genDe = 1'b0;
			end
			cps_pkg::pattern_runs_deemph: genSym = runHigh_q ? 8'hff : 8'h00;
			cps_pkg::pattern_runs_flat:
			begin
				genSym = runHigh_q ? 8'hff : 8'h00;
				genDe = 1'b0;
			end
			default: genSym = cps_pkg::SYM_D00;
		endcase
	end

	cps_fifo #(
		.WIDTH(12),
		.DEPTH(FIFO_DEPTH)
	) uFifo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.inValid(genValid),
		.inReady(genReady),
		.inData({genLf, genDe, genK, 1'b0, genSym}),
		.outValid(fifoValid),
		.outReady(fifoReady),
		.outData(fifoOut)
	);

	// ----------------------------------------
	// Output register stage
	// ----------------------------------------
	assign fifoReady = !txValid || txReady;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			txValid <= 1'b0;
			txSymbol <= '0;
			txIsK <= 1'b0;
			txDeemph <= 1'b1;
			txLfps <= 1'b0;
		end
		else if (fifoReady)
		begin
			txValid <= fifoValid;
			txSymbol <= fifoOut[7:0];
			txIsK <= fifoOut[9];
			txDeemph <= fifoOut[10];
			txLfps <= fifoOut[11];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			complianceActive <= 1'b0;
			txSkpAllowed <= 1'b1;
			patternIndex <= '0;
		end
		else
		begin
			complianceActive <= active;
			txSkpAllowed <= !active && !enterCompliance;
			patternIndex <= 4'(pattern_q);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence pingSeen;
		active && !rstEvt && pingEvt;
	endsequence

	pattern_adv_a:
	assert property (@(posedge mclk) disable iff (sys_rst)
		pingSeen and (pattern_q != cps_pkg::pattern_runs_flat)
		|=> pattern_q == cps_pkg::cps_pattern_t'($past(pattern_q) + 4'h1))
	else $error("ping did not advance pattern");

	pattern_wrap_a:
	assert property (@(posedge mclk) disable iff (sys_rst)
		pingSeen and (pattern_q == cps_pkg::pattern_runs_flat)
		|=> pattern_q == cps_pkg::pattern_scrambled_idle)
	else $error("last pattern did not wrap");

	reset_exit_a:
	assert property (@(posedge mclk) disable iff (sys_rst)
		active && rstEvt |=> !active && complianceExit ##1 !complianceActive)
	else $error("reset LFPS did not end compliance");

	entry_first_a:
	assert property (@(posedge mclk) disable iff (sys_rst)
		!active && enterCompliance |=> pattern_q == cps_pkg::pattern_scrambled_idle)
	else $error("entry did not select first pattern");

	no_skp_a:
	assert property (@(posedge mclk) disable iff (sys_rst)
		active |=> !txSkpAllowed)
	else $error("SKP allowed during compliance");

	hold_pattern_a:
	assert property (@(posedge mclk) disable iff (sys_rst)
		active && !pingEvt && !rstEvt |=> $stable(pattern_q))
	else $error("pattern changed without ping");

	comma_sym_a:
	assert property (@(posedge mclk) disable iff (sys_rst)
		active && pattern_q == cps_pkg::pattern_comma
		|-> genSym == cps_pkg::SYM_K285 && genK)
	else $error("comma pattern symbol wrong");

	lfps_flag_a:
	assert property (@(posedge mclk) disable iff (sys_rst)
		genLf == (pattern_q == cps_pkg::pattern_low_freq_signal))
	else $error("LFPS flag mismatch");

	run_len_a:
	assert property (@(posedge mclk) disable iff (sys_rst)
		runCnt_q < 8'(RUN_BYTES))
	else $error("run length out of range");

	scram_off_a:
	assert property (@(posedge mclk) disable iff (sys_rst)
		active && pattern_q != cps_pkg::pattern_scrambled_idle && genReady
		|=> $stable(lfsr_q))
	else $error("scrambler ran on unscrambled pattern");

endmodule : cps_sequencer

`default_nettype wire

/* File: testbench/cps_link_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module cps_link_partner (
	// Clock
	input wire logic mclk,
	// Symbol sink
	output logic txReady,
	// LFPS detection levels
	output logic pingDetect,
	output logic resetDetect
);
	logic stall = 1'b0;

	initial
	begin
		pingDetect = 1'b0;
		resetDetect = 1'b0;
	end

	assign txReady = ~stall;

	task automatic lfps(input logic isReset);
		@(posedge mclk);
		#1;
		if (isReset)
			resetDetect = 1'b1;
		else
			pingDetect = 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		pingDetect = 1'b0;
		resetDetect = 1'b0;
		repeat (8) @(posedge mclk);
	endtask : lfps

	// Refuse symbols for n cycles
	task automatic hold(input int n);
		@(posedge mclk);
		#1;
		stall = 1'b1;
		repeat (n) @(posedge mclk);
		#1;
		stall = 1'b0;
	endtask : hold
endmodule : cps_link_partner
`default_nettype wire

/* File: testbench/compliance_pattern_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module compliance_pattern_sequencer_tb_top;
	logic mclk;
	logic sysRst;
	logic enterCompliance;
	logic complianceActive, complianceExit, pingDetect, resetDetect;
	logic txValid, txReady, txIsK, txDeemph, txLfps, txSkpAllowed;
	logic [7:0] txSymbol;
	logic [3:0] patternIndex;
	int nFail = 0;
	int compares = 0;
	int cycles = 0;
	logic [7:0] bSym;
	logic [2:0] bFlg;

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	cps_sequencer #(.RUN_LEN(64)) dut_u (.mclk(mclk), .sys_rst(sysRst),
		.enterCompliance(enterCompliance), .complianceActive(complianceActive),
		.complianceExit(complianceExit), .pingDetect(pingDetect), .resetDetect(resetDetect),
		.txValid(txValid), .txReady(txReady), .txSymbol(txSymbol), .txIsK(txIsK),
		.txDeemph(txDeemph), .txLfps(txLfps), .txSkpAllowed(txSkpAllowed),
		.patternIndex(patternIndex));

	cps_link_partner partner_u (.mclk(mclk), .txReady(txReady), .pingDetect(pingDetect),
		.resetDetect(resetDetect));

	task automatic wrapUp;
		$display("Checks %0d, mismatches %0d", compares, nFail);
		if (nFail == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrapUp

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			nFail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Next accepted beat, sampled mid-cycle
	task automatic getBeat;
		int i;
		for (i = 0; i < 100; i++)
		begin
			@(negedge mclk);
			if (txValid === 1'b1 && txReady === 1'b1)
				break;
		end
		chk("beat", 16'h1, {15'h0, i < 100});
		bSym = txSymbol;
		bFlg = {txIsK, txDeemph, txLfps};
	endtask : getBeat

	task automatic tEntry;
		int changes;
		logic [7:0] prev;
		changes = 0;
		@(posedge mclk);
		#1;
		enterCompliance = 1'b1;
		@(posedge mclk);
		#1;
		enterCompliance = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk("skpAllowed", 16'h0, {15'h0, txSkpAllowed});
		chk("active", 16'h1, {15'h0, complianceActive});
		getBeat();
		prev = bSym;
		// First beats carry the seed's all-ones byte
		repeat (23)
		begin
			getBeat();
			chk("flags", 16'h2, {13'h0, bFlg});
			changes += (bSym !== prev);
			prev = bSym;
		end
		chk("scrambled", 16'h1, {15'h0, changes > 2});
	endtask : tEntry

	task automatic tStall;
		logic [7:0] s;
		fork
			partner_u.hold(40);
		join_none
		repeat (6) @(negedge mclk);
		s = txSymbol;
		// Still inside the refusal window
		repeat (12) @(negedge mclk);
		chk("stallValid", 16'h1, {15'h0, txValid});
		chk("stallSym", {8'h0, s}, {8'h0, txSymbol});
		repeat (10) @(posedge mclk);
	endtask : tStall

	task automatic tWalk;
		int i, k, run;
		logic [10:0] e;
		for (i = 1; i <= 9; i++)
		begin
			partner_u.lfps(1'b0);
			for (k = 0; k < 40 && patternIndex !== 4'(i % 9); k++)
				@(negedge mclk);
			chk("index", 16'(i % 9), {12'h0, patternIndex});
			repeat (40) getBeat();
			case (i % 9)
				1: e = {1'b0, 8'h4a, 2'b10};
				2: e = {1'b0, 8'h78, 2'b10};
				3: e = {1'b1, 8'hbc, 2'b10};
				4: e = {1'b0, 8'h00, 2'b11};
				5: e = {1'b1, 8'hfc, 2'b10};
				6: e = {1'b1, 8'hfc, 2'b00};
				7: e = {1'b0, 8'h00, 2'b10};
				8: e = {1'b0, 8'h00, 2'b00};
				default: e = {1'b0, 8'h00, 2'b10};
			endcase
			chk("flags", {13'h0, e[10], e[1:0]}, {13'h0, bFlg});
			if (i < 7 && i != 4)
				chk("symbol", {8'h0, e[9:2]}, {8'h0, bSym});
			chk("skpAllowed", 16'h0, {15'h0, txSkpAllowed});
			if (i == 7)
			begin
				for (k = 0; k < 40 && bSym !== 8'h00; k++)
					getBeat();
				for (k = 0; k < 40 && bSym !== 8'hff; k++)
					getBeat();
				for (run = 0; run < 40 && bSym === 8'hff; run++)
					getBeat();
				chk("runBytes", 16'd8, 16'(run));
				chk("runBits", 16'h1, {15'h0, run * 8 >= 50 && run * 8 <= 250});
				for (run = 0; run < 40 && bSym === 8'h00; run++)
					getBeat();
				chk("zeroBytes", 16'd8, 16'(run));
			end
		end
	endtask : tWalk

	task automatic tExit;
		int k, saw;
		logic [3:0] idx;
		saw = 0;
		fork
			partner_u.lfps(1'b1);
			for (k = 0; k < 17; k++)
			begin
				@(negedge mclk);
				saw += (complianceExit === 1'b1);
			end
		join
		chk("exitPulse", 16'h1, 16'(saw));
		chk("active", 16'h0, {15'h0, complianceActive});
		chk("skpAllowed", 16'h1, {15'h0, txSkpAllowed});
		idx = patternIndex;
		partner_u.lfps(1'b0);
		chk("idleIndex", {12'h0, idx}, {12'h0, patternIndex});
		chk("idleActive", 16'h0, {15'h0, complianceActive});
	endtask : tExit

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			nFail++;
			wrapUp();
		end
	end

	initial
	begin
		sysRst = 1'b1;
		enterCompliance = 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		sysRst = 1'b0;
		tEntry();
		tStall();
		tWalk();
		tExit();
		wrapUp();
	end
endmodule : compliance_pattern_sequencer_tb_top
`default_nettype wire
